//--- verilog/sfdl_top.v
// Digital back end of a bank of ten supply fault detectors.
// Assumes analog comparators take the trip level and range codes driven
// here and return one below-level and one above-level result per channel.
`timescale 1ns/1ps
`default_nettype none

`include "sfdl_defines.vh"

module sfdl_top (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Channel configuration (channel i in slice i, in slice i-5 of dual_is_analog)
  input wire [`SFDL_NUM_CHAN-1:0] chan_enable,
  input wire [`SFDL_NUM_DUAL-1:0] dual_is_analog,
  input wire [2*`SFDL_NUM_CHAN-1:0] chan_mode,
  input wire [2*`SFDL_NUM_CHAN-1:0] range_select,
  input wire [`SFDL_THR_W*`SFDL_NUM_CHAN-1:0] uv_threshold,
  input wire [`SFDL_THR_W*`SFDL_NUM_CHAN-1:0] ov_threshold,
  input wire [`SFDL_HYST_W*`SFDL_NUM_CHAN-1:0] hysteresis_code,
  input wire [`SFDL_US_W*`SFDL_NUM_CHAN-1:0] filter_us,
  // Comparator results and logic pins, asynchronous
  input wire [`SFDL_NUM_CHAN-1:0] cmp_below,
  input wire [`SFDL_NUM_CHAN-1:0] cmp_above,
  input wire [`SFDL_NUM_DUAL-1:0] dual_logic_pin,
  // Drive to the analog comparators
  output wire [2*`SFDL_NUM_CHAN-1:0] range_code,
  output wire [`SFDL_THR_W*`SFDL_NUM_CHAN-1:0] uv_level,
  output wire [`SFDL_THR_W*`SFDL_NUM_CHAN-1:0] ov_level,
  output wire [`SFDL_NUM_CHAN-1:0] chan_active,
  // Status
  output wire [`SFDL_NUM_CHAN-1:0] under_volt_flag,
  output wire [`SFDL_NUM_CHAN-1:0] over_volt_flag,
  output wire [`SFDL_NUM_CHAN-1:0] fault_flag,
  output wire [`SFDL_NUM_CHAN-1:0] fault_event,
  output wire [`SFDL_NUM_DUAL-1:0] logic_level,
  output wire any_fault,
  output wire power_good
);

  // ------------------------------------------------------------------
  // Timing constants
  // ------------------------------------------------------------------

  localparam [`SFDL_CNT_W-1:0] CYC_PER_US = `SFDL_NS_PER_US / `SFDL_CLK_PERIOD_NS;
  localparam [`SFDL_US_W-1:0] FILT_MAX_US = `SFDL_FILT_MAX_US;

  // ------------------------------------------------------------------
  // Synchronised inputs
  // ------------------------------------------------------------------

  wire [`SFDL_NUM_CHAN-1:0] below_sync;
  wire [`SFDL_NUM_CHAN-1:0] above_sync;
  wire [`SFDL_NUM_DUAL-1:0] pin_sync;

  // Comparator results below the trip level
  sfdl_sync3 #(
    .WIDTH(`SFDL_NUM_CHAN)
  ) u_sync_below (
    .clock(clock),
    .resetn(resetn),
    .async_in(cmp_below),
    .sync_out(below_sync)
  );

  // Comparator results above the trip level
  sfdl_sync3 #(
    .WIDTH(`SFDL_NUM_CHAN)
  ) u_sync_above (
    .clock(clock),
    .resetn(resetn),
    .async_in(cmp_above),
    .sync_out(above_sync)
  );

  // Logic pins of the dual-purpose channels
  sfdl_sync3 #(
    .WIDTH(`SFDL_NUM_DUAL)
  ) u_sync_pin (
    .clock(clock),
    .resetn(resetn),
    .async_in(dual_logic_pin),
    .sync_out(pin_sync)
  );

  // ------------------------------------------------------------------
  // Per-channel detector
  // ------------------------------------------------------------------

  wire [`SFDL_NUM_CHAN-1:0] analog_use;
  wire [`SFDL_NUM_CHAN-1:0] digital_use;
  wire [`SFDL_NUM_CHAN-1:0] uv_filt;
  wire [`SFDL_NUM_CHAN-1:0] ov_filt;

  genvar i;
  generate
    for (i = 0; i < `SFDL_NUM_CHAN; i = i + 1) begin : g_chan
      wire [1:0] mode;
      wire [1:0] rsel;
      wire [`SFDL_THR_W-1:0] uv_thr;
      wire [`SFDL_THR_W-1:0] ov_thr;
      wire [`SFDL_HYST_W-1:0] hyst;
      wire [`SFDL_US_W-1:0] us;
      reg [`SFDL_US_W-1:0] us_clamped;
      wire [`SFDL_THR_W:0] uv_sum;
      wire [`SFDL_CNT_W-1:0] limit_nxt;
      wire uv_raw;
      wire ov_raw;
      wire uv_in;
      wire fault_nxt;
      reg [1:0] range_r;
      reg [1:0] range_nxt;
      reg [`SFDL_THR_W-1:0] uv_level_r;
      reg [`SFDL_THR_W-1:0] uv_level_nxt;
      reg [`SFDL_THR_W-1:0] ov_level_r;
      reg [`SFDL_THR_W-1:0] ov_level_nxt;
      reg [`SFDL_CNT_W-1:0] limit_r;
      reg fault_r;
      reg event_r;

      // Field slices of this channel
      assign mode = chan_mode[2*i +: 2];
      assign rsel = range_select[2*i +: 2];
      assign uv_thr = uv_threshold[`SFDL_THR_W*i +: `SFDL_THR_W];
      assign ov_thr = ov_threshold[`SFDL_THR_W*i +: `SFDL_THR_W];
      assign hyst = hysteresis_code[`SFDL_HYST_W*i +: `SFDL_HYST_W];
      assign us = filter_us[`SFDL_US_W*i +: `SFDL_US_W];

      // ------------------------------------------------------------------
      // Channel use
      // ------------------------------------------------------------------

      // Fixed channels are always detectors; dual channels pick one use
      if (i < `SFDL_FIRST_DUAL) begin : g_fixed
        assign analog_use[i] = chan_enable[i];
        assign digital_use[i] = 1'b0;
        assign uv_in = uv_raw;
      end else begin : g_dual
        assign analog_use[i] = chan_enable[i] &
                               dual_is_analog[i-`SFDL_FIRST_DUAL];
        assign digital_use[i] = chan_enable[i] &
                                ~dual_is_analog[i-`SFDL_FIRST_DUAL];
        assign uv_in = analog_use[i] ? uv_raw : pin_sync[i-`SFDL_FIRST_DUAL];
        assign logic_level[i-`SFDL_FIRST_DUAL] = digital_use[i] & uv_filt[i];
      end

      // Range allowed for this kind of channel
      always @* begin
        if (i == `SFDL_HIGH_VOLT_CHAN) begin
          range_nxt = (rsel == `SFDL_RANGE_TOP) ? `SFDL_RANGE_TOP
                                                : `SFDL_RANGE_HIGH;
        end else if (i < `SFDL_FIRST_DUAL) begin
          range_nxt = (rsel == `SFDL_RANGE_TOP) ? `SFDL_RANGE_HIGH : rsel;
        end else begin
          range_nxt = `SFDL_RANGE_LOW;
        end
      end

      // ------------------------------------------------------------------
      // Trip levels
      // ------------------------------------------------------------------

      // Trip code plus hysteresis, one bit wider to catch the carry
      assign uv_sum = {1'b0, uv_thr} + {4'h0, hyst};

      // Undervoltage trip rises by the hysteresis while its fault stands
      always @* begin
        uv_level_nxt = uv_thr;
        if (uv_filt[i]) begin
          if (uv_sum > `SFDL_THR_MAX) begin
            uv_level_nxt = uv_thr | 8'hFF;
          end else begin
            uv_level_nxt = uv_sum[`SFDL_THR_W-1:0];
          end
        end
      end

      // Overvoltage trip falls by the hysteresis while its fault stands
      always @* begin
        ov_level_nxt = ov_thr;
        if (ov_filt[i]) begin
          if (ov_thr < {3'h0, hyst}) begin
            ov_level_nxt = 8'h00;
          end else begin
            ov_level_nxt = ov_thr - {3'h0, hyst};
          end
        end
      end

      // ------------------------------------------------------------------
      // Glitch filter timeout
      // ------------------------------------------------------------------

      // Codes above the longest allowed time act as that time
      always @* begin
        if (us > FILT_MAX_US) begin
          us_clamped = FILT_MAX_US;
        end else begin
          us_clamped = us;
        end
      end

      // Timeout in clock cycles; the longest code still fits the counter
      assign limit_nxt = {5'h00, us_clamped} * CYC_PER_US;

      // Mode gates which comparator results can raise a fault
      assign uv_raw = analog_use[i] & mode[`SFDL_MODE_UV_BIT] & below_sync[i];
      assign ov_raw = analog_use[i] & mode[`SFDL_MODE_OV_BIT] & above_sync[i];
      assign fault_nxt = analog_use[i] & (uv_filt[i] | ov_filt[i]);

      // ------------------------------------------------------------------
      // Registered drive
      // ------------------------------------------------------------------

      // Registered drive, timeout and fault edge
      always @(posedge clock) begin
        if (!resetn) begin
          range_r <= `SFDL_RANGE_LOW;
          uv_level_r <= 8'h00;
          ov_level_r <= 8'hFF;
          limit_r <= {`SFDL_CNT_W{1'b0}};
          fault_r <= 1'b0;
          event_r <= 1'b0;
        end else begin
          range_r <= range_nxt;
          uv_level_r <= uv_level_nxt;
          ov_level_r <= ov_level_nxt;
          limit_r <= limit_nxt;
          fault_r <= fault_nxt;
          event_r <= fault_nxt & ~fault_r;
        end
      end

      // ------------------------------------------------------------------
      // Glitch filters
      // ------------------------------------------------------------------

      // Undervoltage path, also the logic-input path of a dual channel
      sfdl_glitch_filter u_filt_uv (
        .clock(clock),
        .resetn(resetn),
        .enable(chan_enable[i]),
        .limit(limit_r),
        .raw_in(uv_in),
        .filt_out(uv_filt[i])
      );

      // Overvoltage path
      sfdl_glitch_filter u_filt_ov (
        .clock(clock),
        .resetn(resetn),
        .enable(analog_use[i]),
        .limit(limit_r),
        .raw_in(ov_raw),
        .filt_out(ov_filt[i])
      );

      // ------------------------------------------------------------------
      // Channel outputs
      // ------------------------------------------------------------------

      // Per-channel outputs; the under- and overvoltage flags are gated so a dropped channel reads clear
      assign range_code[2*i +: 2] = range_r;
      assign uv_level[`SFDL_THR_W*i +: `SFDL_THR_W] = uv_level_r;
      assign ov_level[`SFDL_THR_W*i +: `SFDL_THR_W] = ov_level_r;
      assign under_volt_flag[i] = analog_use[i] & uv_filt[i];
      assign over_volt_flag[i] = analog_use[i] & ov_filt[i];
      assign fault_flag[i] = fault_r;
      assign fault_event[i] = event_r;
    end
  endgenerate

  // ------------------------------------------------------------------
  // Bank summary
  // ------------------------------------------------------------------

  reg any_fault_r;
  reg power_good_r;
  wire any_fault_nxt;
  wire power_good_nxt;

  // Summary terms of the whole bank
  assign any_fault_nxt = |fault_flag;
  assign power_good_nxt = (|analog_use) & ~(|fault_flag);

  // Any raised fault, and good when at least one analog channel is in use and every one is clear
  always @(posedge clock) begin
    if (!resetn) begin
      any_fault_r <= 1'b0;
      power_good_r <= 1'b0;
    end else begin
      any_fault_r <= any_fault_nxt;
      power_good_r <= power_good_nxt;
    end
  end

  assign chan_active = analog_use;
  assign any_fault = any_fault_r;
  assign power_good = power_good_r;

endmodule

`default_nettype wire

//--- verilog/sfdl_defines.vh
// Constants for the supply fault detector back end.
// Assumes inclusion by bare name from the top and glitch filter design files of the block.
`ifndef SFDL_DEFINES_VH
`define SFDL_DEFINES_VH

// ------------------------------------------------------------------
// Channel layout
// ------------------------------------------------------------------
`define SFDL_NUM_CHAN 10
`define SFDL_NUM_DUAL 5
`define SFDL_FIRST_DUAL 5
`define SFDL_HIGH_VOLT_CHAN 0

// ------------------------------------------------------------------
// Field widths
// ------------------------------------------------------------------
`define SFDL_THR_W 8
`define SFDL_HYST_W 5
`define SFDL_US_W 7
`define SFDL_CNT_W 12

// ------------------------------------------------------------------
// Detection mode: bit 0 enables undervoltage, bit 1 overvoltage
// ------------------------------------------------------------------
`define SFDL_MODE_OFF 2'h0
`define SFDL_MODE_UV 2'h1
`define SFDL_MODE_OV 2'h2
`define SFDL_MODE_WINDOW 2'h3
`define SFDL_MODE_UV_BIT 0
`define SFDL_MODE_OV_BIT 1

// ------------------------------------------------------------------
// Input range codes: 0.573 V/0.802 V, 1.25 V/1.75 V, 2.5 V/3.5 V, 6.0 V/8.4 V
// ------------------------------------------------------------------
`define SFDL_RANGE_LOW 2'h0
`define SFDL_RANGE_MID 2'h1
`define SFDL_RANGE_HIGH 2'h2
`define SFDL_RANGE_TOP 2'h3

// ------------------------------------------------------------------
// Code limits and timing
// ------------------------------------------------------------------
`define SFDL_THR_MAX 9'h0FF
`define SFDL_CLK_PERIOD_NS 25
`define SFDL_NS_PER_US 1000
`define SFDL_FILT_MAX_US 100

`endif

//--- verilog/sfdl_sync3.v
// Three-stage synchroniser for asynchronous comparator and pin levels.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module sfdl_sync3 #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;
  reg [WIDTH-1:0] level_r;

  // A bit moves only once the second and third stages agree
  always @(posedge clock) begin
    if (!resetn) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
      level_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r <= (stage2_r & stage3_r) | (level_r & (stage2_r | stage3_r));
    end
  end

  assign sync_out = level_r;

endmodule

`default_nettype wire

//--- verilog/sfdl_glitch_filter.v
// Glitch filter for one comparator or logic level.
// Assumes the timeout limit is already in clock cycles and is stable.
`timescale 1ns/1ps
`default_nettype none

`include "sfdl_defines.vh"

module sfdl_glitch_filter (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Control
  input wire enable,
  input wire [`SFDL_CNT_W-1:0] limit,
  // Level in and out
  input wire raw_in,
  output wire filt_out
);

  reg last_r;
  reg [`SFDL_CNT_W-1:0] cnt_r;
  reg out_r;

  // Counter restarts on each change; output takes the level once stable
  always @(posedge clock) begin
    if (!resetn || !enable) begin
      last_r <= 1'b0;
      cnt_r <= {`SFDL_CNT_W{1'b0}};
      out_r <= 1'b0;
    end else if (raw_in != last_r) begin
      last_r <= raw_in;
      cnt_r <= {`SFDL_CNT_W{1'b0}};
    end else begin
      if (cnt_r < limit) begin
        cnt_r <= cnt_r + 1'b1;
      end
      if (cnt_r >= limit) begin
        out_r <= last_r;
      end
    end
  end

  assign filt_out = out_r;

endmodule

`default_nettype wire

//--- verification/sfdl_assertions.sv
// Checker for the fault detector top, watching its ports only.
// Assumes ten channels and the port widths of the top.
`timescale 1ns/1ps
`default_nettype none
module sfdl_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Inputs
  input wire logic [9:0] chan_enable,
  input wire logic [4:0] dual_is_analog,
  input wire logic [79:0] uv_threshold,
  input wire logic [79:0] ov_threshold,
  input wire logic [49:0] hysteresis_code,
  input wire logic [9:0] cmp_above,
  // Outputs
  input wire logic [79:0] uv_level,
  input wire logic [79:0] ov_level,
  input wire logic [9:0] chan_active,
  input wire logic [9:0] under_volt_flag,
  input wire logic [9:0] over_volt_flag,
  input wire logic [9:0] fault_flag,
  input wire logic [9:0] fault_event,
  input wire logic any_fault
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!resetn);
  // Saturating moves of a trip code
  function automatic logic [7:0] up(input logic [7:0] t, input logic [4:0] h);
    return (t > 8'hFF - h) ? 8'hFF : t + h;
  endfunction
  function automatic logic [7:0] dn(input logic [7:0] t, input logic [4:0] h);
    return (t < h) ? 8'h00 : t - h;
  endfunction
  // Status relations
  a_fault_or: assert property ($past(resetn) |->
    fault_flag == $past(under_volt_flag | over_volt_flag)) else $error("fault_flag wrong");
  a_event_pulse: assert property ($past(resetn) |->
    fault_event == (fault_flag & ~$past(fault_flag))) else $error("fault_event wrong");
  a_any_fault: assert property ($past(resetn) |->
    any_fault == |$past(fault_flag)) else $error("any_fault wrong");
  a_active_def: assert property (
    chan_active == (chan_enable & {dual_is_analog, 5'h1F})) else $error("chan_active wrong");
  a_uv_gate: assert property (
    (under_volt_flag & ~chan_active) == 10'h000) else $error("flag on idle channel");
  a_ov_gate: assert property (
    (over_volt_flag & ~chan_active) == 10'h000) else $error("ov flag on idle channel");
  // Per-channel trip levels and filter cause
  for (genvar i = 0; i < 10; i++) begin : g_ch
    a_uv_trip: assert property ($past(resetn && chan_active[i]) |->
      uv_level[8*i+:8] == up($past(uv_threshold[8*i+:8]),
      $past(under_volt_flag[i]) ? $past(hysteresis_code[5*i+:5]) : 5'h00))
      else $error("uv_level wrong");
    a_ov_trip: assert property ($past(resetn && chan_active[i]) |->
      ov_level[8*i+:8] == dn($past(ov_threshold[8*i+:8]),
      $past(over_volt_flag[i]) ? $past(hysteresis_code[5*i+:5]) : 5'h00))
      else $error("ov_level wrong");
    a_ov_cause: assert property ($rose(over_volt_flag[i]) |->
      $past(cmp_above[i], 5) || $past(cmp_above[i], 6)) else $error("flag without cause");
  end
endmodule
bind sfdl_top sfdl_checker u_chk (
  .clock(clock), .resetn(resetn), .chan_enable(chan_enable), .dual_is_analog(dual_is_analog),
  .uv_threshold(uv_threshold), .ov_threshold(ov_threshold),
  .hysteresis_code(hysteresis_code), .cmp_above(cmp_above), .uv_level(uv_level),
  .ov_level(ov_level), .chan_active(chan_active), .under_volt_flag(under_volt_flag),
  .over_volt_flag(over_volt_flag), .fault_flag(fault_flag), .fault_event(fault_event),
  .any_fault(any_fault)
);
`default_nettype wire

//--- verification/sfdl_comparator_model.sv
// Analog comparator bank seen as codes on the range of each channel.
// Assumes each supply is given as a code on the same scale as the trips.
`timescale 1ns/1ps
`default_nettype none
module sfdl_comparator_model (
  // Supply level per channel
  input wire logic [79:0] supply_code,
  // Trip levels from the block
  input wire logic [79:0] uv_level,
  input wire logic [79:0] ov_level,
  // Comparator results
  output logic [9:0] cmp_below,
  output logic [9:0] cmp_above
);
  // Compares all the time, whether or not the channel is in use
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      cmp_below[i] = supply_code[8*i+:8] < uv_level[8*i+:8];
      cmp_above[i] = supply_code[8*i+:8] > ov_level[8*i+:8];
    end
  end
endmodule
`default_nettype wire

//--- verification/sfdl_tb_top.sv
// Self-checking bench for the fault detector top.
// Assumes the comparator model closes the loop on the trip levels.
`timescale 1ns/1ps
`default_nettype none
module sfdl_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] chan_enable = 10'h3FF;
  logic [4:0] dual_is_analog = 5'h1F;
  logic [19:0] chan_mode = 20'hFFFFF;
  logic [19:0] range_select = 20'h00000;
  logic [79:0] uv_threshold = {10{8'h40}};
  logic [79:0] ov_threshold = {10{8'hC0}};
  logic [49:0] hysteresis_code = {10{5'h05}};
  logic [69:0] filter_us = {10{7'h01}};
  logic [79:0] supply_code = {10{8'h80}};
  logic [4:0] dual_logic_pin = 5'h00;
  logic [9:0] cmp_below, cmp_above, chan_active, under_volt_flag, over_volt_flag;
  logic [9:0] fault_flag, fault_event;
  logic [9:0] ov_seen = 10'h000;
  logic [19:0] range_code;
  logic [79:0] uv_level, ov_level;
  logic [4:0] logic_level;
  logic any_fault, power_good, ev;
  int miscompares = 0;
  int samples_checked = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  sfdl_top dut (
    .clock(clock), .resetn(resetn), .chan_enable(chan_enable), .dual_is_analog(dual_is_analog),
    .chan_mode(chan_mode), .range_select(range_select), .uv_threshold(uv_threshold),
    .ov_threshold(ov_threshold), .hysteresis_code(hysteresis_code), .filter_us(filter_us),
    .cmp_below(cmp_below), .cmp_above(cmp_above), .dual_logic_pin(dual_logic_pin),
    .range_code(range_code), .uv_level(uv_level), .ov_level(ov_level),
    .chan_active(chan_active), .under_volt_flag(under_volt_flag),
    .over_volt_flag(over_volt_flag), .fault_flag(fault_flag), .fault_event(fault_event),
    .logic_level(logic_level), .any_fault(any_fault), .power_good(power_good)
  );
  sfdl_comparator_model cmp (
    .supply_code(supply_code), .uv_level(uv_level), .ov_level(ov_level),
    .cmp_below(cmp_below), .cmp_above(cmp_above)
  );
  // Remembers any overvoltage flag seen since the last clear
  always @(posedge clock) begin
    ov_seen <= ov_seen | over_volt_flag;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_vec(input string what, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Illegal range selects are folded onto each channel's own ranges
  task automatic t_ranges;
    range_select = 20'hFFFFF;
    tick(2);
    chk_vec("range_code", 20'h002AB, range_code);
    range_select = 20'h55555;
    tick(2);
    chk_vec("range_code", 20'h00156, range_code);
  endtask
  // Undervoltage lag, event pulse and hysteresis on channel 1
  task automatic t_uv_hyst;
    supply_code[15:8] = 8'h30;
    tick(35);
    chk_bit("uv early", 1'b0, under_volt_flag[1]);
    for (int n = 0; n < 20 && under_volt_flag[1] !== 1'b1; n++) begin
      tick(1);
    end
    chk_bit("uv raised", 1'b1, under_volt_flag[1]);
    ev = 1'b0;
    repeat (5) begin
      tick(1);
      ev = ev | fault_event[1];
    end
    chk_bit("fault_event", 1'b1, ev);
    chk_bit("any_fault", 1'b1, any_fault);
    chk_vec("uv_level", 20'h00045, {12'h000, uv_level[15:8]});
    supply_code[15:8] = 8'h43;
    tick(80);
    chk_bit("uv held", 1'b1, under_volt_flag[1]);
    supply_code[15:8] = 8'h50;
    tick(80);
    chk_bit("uv cleared", 1'b0, under_volt_flag[1]);
  endtask
  // Short and long overvoltage pulses, and a zero timeout
  task automatic t_glitch;
    ov_seen = 10'h000;
    supply_code[23:16] = 8'hD0;
    tick(36);
    supply_code[23:16] = 8'h80;
    tick(60);
    chk_bit("short pulse", 1'b0, ov_seen[2]);
    supply_code[23:16] = 8'hD0;
    tick(60);
    chk_bit("long pulse", 1'b1, over_volt_flag[2]);
    supply_code[23:16] = 8'h80;
    filter_us[48:42] = 7'h00;
    supply_code[55:48] = 8'hD0;
    tick(10);
    chk_bit("no timeout", 1'b1, over_volt_flag[6]);
    supply_code[55:48] = 8'h80;
    tick(80);
  endtask
  // Every detection mode on channel 3
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      chan_mode[7:6] = m[1:0];
      supply_code[31:24] = 8'h30;
      tick(60);
      chk_bit("mode uv", m[0], under_volt_flag[3]);
      supply_code[31:24] = 8'hD0;
      tick(60);
      chk_bit("mode ov", m[1], over_volt_flag[3]);
      supply_code[31:24] = 8'h80;
      tick(60);
    end
  endtask
  // Disabled channel, then dual-purpose channel 5 in logic and analog use
  task automatic t_use;
    chan_enable[4] = 1'b0;
    supply_code[39:32] = 8'h30;
    tick(60);
    chk_bit("off uv", 1'b0, under_volt_flag[4]);
    chan_enable[4] = 1'b1;
    tick(60);
    chk_bit("on uv", 1'b1, under_volt_flag[4]);
    supply_code[39:32] = 8'h80;
    dual_is_analog[0] = 1'b0;
    supply_code[47:40] = 8'h30;
    dual_logic_pin[0] = 1'b1;
    tick(60);
    chk_bit("dual uv", 1'b0, under_volt_flag[5]);
    chk_bit("logic high", 1'b1, logic_level[0]);
    dual_is_analog[0] = 1'b1;
    tick(60);
    chk_bit("logic off", 1'b0, logic_level[0]);
    chk_bit("dual uv on", 1'b1, under_volt_flag[5]);
    supply_code[47:40] = 8'h80;
    tick(80);
  endtask
  // Timeout codes above the maximum act as the maximum
  task automatic t_clamp;
    filter_us[55:49] = 7'h7F;
    supply_code[63:56] = 8'h30;
    tick(3950);
    chk_bit("clamp early", 1'b0, under_volt_flag[7]);
    tick(100);
    chk_bit("clamp late", 1'b1, under_volt_flag[7]);
    supply_code[63:56] = 8'h80;
    tick(4100);
    chk_bit("power_good", 1'b1, power_good);
  endtask
  // Main sequence
  initial begin
    tick(16);
    resetn = 1'b1;
    tick(2);
    t_ranges();
    t_uv_hyst();
    t_glitch();
    t_modes();
    t_use();
    t_clamp();
    end_of_test();
  end
  // Watchdog
  initial begin
    #(25 * 20000);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
